// >>> design/rbt_xcvr.sv
`timescale 1ns/100ps

module rbt_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic          push;
  logic          pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    // depth need not be a power of two
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count_r != FULL_CNT);
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop) rd_ptr_r <= ptr_inc(rd_ptr_r);
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end

  property p_count_bound;
    @(posedge clk) disable iff (!nrst) count_r <= FULL_CNT;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("fifo count above depth");

  property p_count_step;
    @(posedge clk) disable iff (!nrst)
      (push && !pop) |=> count_r == $past(count_r) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("fifo count did not rise on push");
endmodule

// one direction: pin sync, latch/flop store, fifo, registered driver
module rbt_path #(
  parameter int W        = 18,
  parameter int DEPTH    = 8,
  parameter bit OE_LOW   = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  input  wire logic         latch_enable,
  input  wire logic         path_clock,
  input  wire logic         output_enable,
  input  wire logic         output_stall,
  output logic [W-1:0]      dout_r,
  output logic              oe_n_r
);
  logic [W-1:0] din_s1, din_s2;
  logic         le_s1, le_s2;
  logic         pc_s1, pc_s2, pc_s3;
  logic         oe_s1, oe_s2;
  logic [W-1:0] last_r;
  logic [W-1:0] cap_r;
  logic         pend_r;
  logic         fall;
  logic         trans;
  logic         event_s;
  logic         in_ready;
  logic         f_valid;
  logic [W-1:0] f_data;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_s1 <= '0;
      din_s2 <= '0;
      le_s1  <= rbt_pkg::SYNC_RST;
      le_s2  <= rbt_pkg::SYNC_RST;
      pc_s1  <= rbt_pkg::SYNC_RST;
      pc_s2  <= rbt_pkg::SYNC_RST;
      pc_s3  <= rbt_pkg::SYNC_RST;
      // enable syncs start inactive, so no pin is driven just after reset
      oe_s1  <= OE_LOW ? rbt_pkg::OE_N_RST : rbt_pkg::SYNC_RST;
      oe_s2  <= OE_LOW ? rbt_pkg::OE_N_RST : rbt_pkg::SYNC_RST;
    end else if (ce) begin
      din_s1 <= din;
      din_s2 <= din_s1;
      le_s1  <= latch_enable;
      le_s2  <= le_s1;
      pc_s1  <= path_clock;
      pc_s2  <= pc_s1;
      pc_s3  <= pc_s2;
      oe_s1  <= output_enable;
      oe_s2  <= oe_s1;
    end
  end

  // clock pin is sampled, so its pulses must outlast one clk period
  assign fall    = !le_s2 && pc_s3 && !pc_s2;
  assign trans   = le_s2 && (din_s2 != last_r);
  // a steady path clock with latch closed makes no event: store holds
  assign event_s = fall || trans;

  // a new capture overwrites one still waiting for fifo room
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_r <= '0;
      cap_r  <= '0;
      pend_r <= 1'b0;
    end else if (ce) begin
      if (event_s) begin
        last_r <= din_s2;
        cap_r  <= din_s2;
        pend_r <= 1'b1;
      end else if (in_ready) begin
        pend_r <= 1'b0;
      end
    end
  end

  rbt_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (pend_r),
    .in_ready  (in_ready),
    .in_data   (cap_r),
    .out_valid (f_valid),
    .out_ready (!output_stall),
    .out_data  (f_data)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout_r <= '0;
    end else if (ce && f_valid && !output_stall) begin
      dout_r <= f_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_n_r <= rbt_pkg::OE_N_RST;
    end else if (ce) begin
      oe_n_r <= OE_LOW ? oe_s2 : !oe_s2;
    end
  end

  property p_fall_capture;
    @(posedge clk) disable iff (!nrst)
      (ce && fall) |=> pend_r && cap_r == $past(din_s2);
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("fall not captured");

  property p_transparent;
    @(posedge clk) disable iff (!nrst)
      (ce && le_s2 && din_s2 != last_r) |=> cap_r == $past(din_s2) && last_r == cap_r;
  endproperty
  a_transparent: assert property (p_transparent) else $error("transparent miss");

  property p_hold_high;
    @(posedge clk) disable iff (!nrst)
      (!le_s2 && pc_s2 && pc_s3) |=> $stable(cap_r);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("store moved, clock high");

  property p_hold_low;
    @(posedge clk) disable iff (!nrst)
      (!le_s2 && !pc_s2 && !pc_s3) |=> $stable(cap_r) && $stable(last_r);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("store moved, clock low");

  property p_hold_closed;
    @(posedge clk) disable iff (!nrst)
      (!le_s2 && !fall) |=> $stable(cap_r);
  endproperty
  a_hold_closed: assert property (p_hold_closed) else $error("store moved while closed");

  property p_oe;
    @(posedge clk) disable iff (!nrst)
      $past(ce) |-> oe_n_r == (OE_LOW ? $past(oe_s2) : !$past(oe_s2));
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong polarity");

  property p_drive_update;
    @(posedge clk) disable iff (!nrst)
      (ce && f_valid && !output_stall) |=> dout_r == $past(f_data);
  endproperty
  a_drive_update: assert property (p_drive_update) else $error("output not updated");

  property p_drive_stall;
    @(posedge clk) disable iff (!nrst)
      (output_stall || !ce) |=> $stable(dout_r);
  endproperty
  a_drive_stall: assert property (p_drive_stall)
    else $error("output moved while stalled");

  property p_pend_keep;
    @(posedge clk) disable iff (!nrst)
      (ce && pend_r && !in_ready) |=> pend_r;
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("pending capture lost");
endmodule

module rbt_xcvr #(
  parameter int W     = rbt_pkg::DATA_W,
  parameter int DEPTH = rbt_pkg::FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] a_in,
  output logic [W-1:0]      a_out,
  output logic              a_oe_n,
  input  wire logic [W-1:0] b_in,
  output logic [W-1:0]      b_out,
  output logic              b_oe_n,
  input  wire logic         a_to_b_output_enable,
  input  wire logic         b_to_a_output_enable_n,
  input  wire logic         a_to_b_latch_enable,
  input  wire logic         b_to_a_latch_enable,
  input  wire logic         a_to_b_clock,
  input  wire logic         b_to_a_clock,
  input  wire logic         a_stall,
  input  wire logic         b_stall
);
  // two independent paths; a pin is input one way and driver the other
  rbt_path #(.W(W), .DEPTH(DEPTH), .OE_LOW(1'b0)) u_a_to_b (
    .clk           (clk),
    .nrst          (nrst),
    .ce            (ce),
    .din           (a_in),
    .latch_enable  (a_to_b_latch_enable),
    .path_clock    (a_to_b_clock),
    .output_enable (a_to_b_output_enable),
    .output_stall  (b_stall),
    .dout_r        (b_out),
    .oe_n_r        (b_oe_n)
  );

  rbt_path #(.W(W), .DEPTH(DEPTH), .OE_LOW(1'b1)) u_b_to_a (
    .clk           (clk),
    .nrst          (nrst),
    .ce            (ce),
    .din           (b_in),
    .latch_enable  (b_to_a_latch_enable),
    .path_clock    (b_to_a_clock),
    .output_enable (b_to_a_output_enable_n),
    .output_stall  (a_stall),
    .dout_r        (a_out),
    .oe_n_r        (a_oe_n)
  );
endmodule

// >>> shared/rbt_pkg.sv
// Notes on behaviour
// - 18-bit path each way, separate controls.
// - latch enable high makes path transparent.
// - latch enable low, steady clock: hold.
// - latch enable low: capture on clock fall.
// - a-to-b output enable low floats B.
// - b-to-a path mirrors a-to-b path.
// - b-to-a output enable is active low.
// - clock held high: output keeps level.
// - clock low before enable fell: hold.
// - each pin is input and three-state output.
package rbt_pkg;
  localparam int          DATA_W     = 18;
  localparam int          FIFO_DEPTH = 8;
  localparam logic        OE_N_RST   = 1'b1;
  localparam logic        SYNC_RST   = 1'b0;
endpackage

// >>> sim/rbt_bus_model.sv
`timescale 1ns/100ps

// far side of both buses: a pin carries the device value only while it drives
module rbt_bus_model #(
  parameter int W = rbt_pkg::DATA_W
) (
  input  wire logic [W-1:0] a_out,
  input  wire logic         a_oe_n,
  input  wire logic [W-1:0] b_out,
  input  wire logic         b_oe_n,
  input  wire logic [W-1:0] a_src,
  input  wire logic [W-1:0] b_src,
  output logic [W-1:0]      a_in,
  output logic [W-1:0]      b_in
);
  // far side backs off while the device drives, so no contention
  assign a_in = a_oe_n ? a_src : a_out;
  assign b_in = b_oe_n ? b_src : b_out;
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  localparam int W = rbt_pkg::DATA_W;
  logic         clk = 0, nrst = 0, ce = 1;
  logic [W-1:0] a_src = 18'h0_0000, b_src = 18'h0_0000;
  logic [W-1:0] a_in, b_in, a_out, b_out, last;
  logic         a_oe_n, b_oe_n;
  logic         oe_ab = 0, oe_ba_n = 1, le_ab = 1, le_ba = 1;
  logic         ck_ab = 0, ck_ba = 0, b_stall = 0, a_stall = 0;
  int           n_errors = 0, tests_run = 0, n_chg;

  rbt_xcvr dut (.clk(clk), .nrst(nrst), .ce(ce), .a_in(a_in), .a_out(a_out),
    .a_oe_n(a_oe_n), .b_in(b_in), .b_out(b_out), .b_oe_n(b_oe_n),
    .a_to_b_output_enable(oe_ab), .b_to_a_output_enable_n(oe_ba_n),
    .a_to_b_latch_enable(le_ab), .b_to_a_latch_enable(le_ba),
    .a_to_b_clock(ck_ab), .b_to_a_clock(ck_ba), .a_stall(a_stall), .b_stall(b_stall));
  rbt_bus_model u_bus (.a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n),
    .a_src(a_src), .b_src(b_src), .a_in(a_in), .b_in(b_in));

  initial forever #4 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_reset();
    check(a_out, 18'h0_0000);
    check(b_out, 18'h0_0000);
    check(W'({a_oe_n, b_oe_n}), 18'h0_0003);
  endtask

  task automatic t_a_to_b();
    oe_ab = 1;
    a_src = 18'h2_5a5a;
    tick(10);
    check(b_out, 18'h2_5a5a);
    check(W'(b_oe_n), 18'h0_0000);
    le_ab = 0;
    tick(4);
    a_src = 18'h1_3c3c;
    tick(12);
    check(b_out, 18'h2_5a5a);
    ck_ab = 1;
    tick(12);
    check(b_out, 18'h2_5a5a);
    ck_ab = 0;
    tick(12);
    check(b_out, 18'h1_3c3c);
  endtask

  task automatic t_ce_and_off();
    ce = 0;
    le_ab = 1;
    a_src = 18'h0_0f0f;
    tick(12);
    check(b_out, 18'h1_3c3c);
    ce = 1;
    tick(10);
    check(b_out, 18'h0_0f0f);
    oe_ab = 0;
    le_ab = 0;
    tick(6);
    check(W'(b_oe_n), 18'h0_0001);
  endtask

  task automatic t_b_to_a();
    oe_ba_n = 0;
    b_src = 18'h3_0303;
    tick(10);
    check(a_out, 18'h3_0303);
    check(W'(a_oe_n), 18'h0_0000);
    le_ba = 0;
    tick(4);
    ck_ba = 1;
    b_src = 18'h0_7777;
    tick(12);
    check(a_out, 18'h3_0303);
    ck_ba = 0;
    tick(12);
    check(a_out, 18'h0_7777);
    a_stall = 1;
    le_ba = 1;
    b_src = 18'h0_1234;
    tick(12);
    check(a_out, 18'h0_7777);
    a_stall = 0;
    tick(4);
    check(a_out, 18'h0_1234);
    oe_ba_n = 1;
    tick(6);
    check(W'(a_oe_n), 18'h0_0001);
  endtask

  // ten words into eight slots plus one pending slot: the ninth is overwritten
  task automatic t_fifo();
    oe_ab = 1;
    a_src = 18'h1_0000;
    le_ab = 1;
    tick(12);
    b_stall = 1;
    for (int k = 1; k <= 10; k++) begin
      a_src = 18'h1_0000 + W'(k);
      tick(8);
    end
    last = b_out;
    n_chg = 0;
    b_stall = 0;
    for (int i = 0; i < 200; i++) begin
      tick(1);
      if (b_out !== last) n_chg++;
      if (n_chg == 1 && b_out !== last) check(b_out, 18'h1_0001);
      last = b_out;
    end
    check(W'(n_chg), 18'h0_0009);
    check(b_out, 18'h1_000a);
  endtask

  initial begin
    #20000;
    n_errors++;
    final_report();
  end

  initial begin
    tick(3);
    t_reset();
    nrst = 1;
    tick(1);
    t_reset();
    t_a_to_b();
    t_ce_and_off();
    t_b_to_a();
    t_fifo();
    final_report();
  end
endmodule
